// ==== nvsram_host_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// host side controller for the nonvolatile sram
// =====================================================
module nvsram_host_ctrl #(
    parameter logic [nvsram_host_pkg::TMR_W-1:0] STORE_WAIT =
        nvsram_host_pkg::TMR_W'(nvsram_host_pkg::STORE_WAIT_CYC),
    parameter logic [nvsram_host_pkg::TMR_W-1:0] BOOT_WAIT =
        nvsram_host_pkg::TMR_W'(nvsram_host_pkg::BOOT_WAIT_CYC)
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    // user request side
    input wire logic req_valid,
    output logic req_ready,
    input wire nvsram_host_pkg::op_t req_op,
    input wire logic [nvsram_host_pkg::ADDR_W-1:0] req_addr,
    input wire logic [nvsram_host_pkg::DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [nvsram_host_pkg::DATA_W-1:0] rsp_rdata,
    output logic busy,
    // memory pins
    output logic cs_n,
    output logic oe_n,
    output logic strobe_n,
    output logic [nvsram_host_pkg::ADDR_W-1:0] addr_pins,
    input wire logic [nvsram_host_pkg::DATA_W-1:0] data_pins_in,
    output logic [nvsram_host_pkg::DATA_W-1:0] data_pins_out,
    output logic data_pins_oe
);
    import nvsram_host_pkg::*;

    // =====================================================
    // helpers
    // =====================================================
    // address of sequence step, last one chooses the transfer
    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] idx,
                                                   input logic recall);
        logic [ADDR_W-1:0] a;
        case (idx)
            3'h0: a = SEQ_A0;
            3'h1: a = SEQ_A1;
            3'h2: a = SEQ_A2;
            3'h3: a = SEQ_A3;
            3'h4: a = SEQ_A4;
            default: a = recall ? SEQ_RECALL : SEQ_STORE;
        endcase
        return a;
    endfunction

    // software transfer requests run the six read sequence
    function automatic logic is_nv_op(input op_t op);
        return (op == OP_STORE) || (op == OP_RECALL);
    endfunction

    // a long wait is over once the loaded count has run down; the load
    // cycle itself is skipped because the counter still holds zero then
    function automatic logic wait_over(input logic loading, input logic expired);
        return !loading && expired;
    endfunction

    // =====================================================
    // state and long wait counter
    // =====================================================

    ctl_t st_q; // all controller state
    ctl_t st_d; // next state
    nv_timer_if tif (); // link to long wait counter

    // long wait counter, shared by the boot wait and the transfer waits
    nv_wait_timer i_nv_wait_timer (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .t(tif.tmr)
    );

    // load strobe and count come straight from flops
    assign tif.load = st_q.tmr_load;
    assign tif.count = st_q.tmr_count;

    // =====================================================
    // next state
    // =====================================================
    always_comb begin
        st_d = st_q;
        // one cycle strobes drop unless a state raises them
        st_d.rsp = 1'b0;
        st_d.tmr_load = 1'b0;
        // three stage pin synchroniser for read data
        st_d.s1 = data_pins_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // one branch per controller state
        case (st_q.st)
            ST_BOOT: begin
                // wait out power up recall before any access
                if (!st_q.boot_go) begin
                    st_d.boot_go = 1'b1;
                    st_d.tmr_load = 1'b1;
                    st_d.tmr_count = BOOT_WAIT;
                end else if (wait_over(st_q.tmr_load, tif.expired)) begin
                    // memory has finished its own power up copy
                    st_d.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // take one request
                // req_ready is high only here, so requests wait elsewhere
                if (req_valid) begin
                    st_d.op = req_op;
                    st_d.wdata = req_wdata;
                    st_d.seq = 3'h0;
                    if (is_nv_op(req_op)) begin
                        // first sequence address, same for both transfers
                        st_d.addr = seq_addr(3'h0, req_op == OP_RECALL);
                    end else begin
                        // plain access goes to the caller's byte
                        st_d.addr = req_addr;
                    end
                    // drive write data ahead of the strobe
                    st_d.dq_oe = (req_op == OP_WRITE);
                    st_d.st = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // address settled one cycle before cs_n falls
                // sequence reads keep strobe_n and oe_n high
                st_d.cs_n = 1'b0;
                st_d.oe_n = (st_q.op != OP_READ);
                st_d.strobe_n = (st_q.op != OP_WRITE);
                st_d.cnt = CNT_W'(ACC_LOW_CYC - 1);
                st_d.st = ST_ACT;
            end
            ST_ACT: begin
                // hold cs_n low for the full access
                // a read whose data never settles stays selected until it does
                if (st_q.cnt != '0) begin
                    st_d.cnt = st_q.cnt - 4'h1;
                end else if (st_q.op != OP_READ || st_q.s2 == st_q.s3) begin
                    // read data counts once last two stages agree
                    // only a plain read updates the answer byte
                    if (st_q.op == OP_READ) begin
                        st_d.rdata = st_q.s3;
                    end
                    st_d.cs_n = 1'b1;
                    st_d.oe_n = 1'b1;
                    st_d.strobe_n = 1'b1;
                    st_d.st = ST_GAP;
                end
            end
            ST_GAP: begin
                // address and data held one cycle past cs_n rise
                st_d.dq_oe = 1'b0;
                if (st_q.op == OP_READ || st_q.op == OP_WRITE) begin
                    // plain access done, answer for one cycle
                    st_d.rsp = 1'b1;
                    st_d.st = ST_IDLE;
                end else if (st_q.seq != 3'(SEQ_LAST)) begin
                    // next step follows at once, nothing in between
                    st_d.seq = st_q.seq + 3'h1;
                    st_d.addr = seq_addr(st_q.seq + 3'h1, st_q.op == OP_RECALL);
                    st_d.st = ST_SETUP;
                end else begin
                    // transfer started, leave the pins alone
                    st_d.tmr_load = 1'b1;
                    // store waits STORE_WAIT cycles, recall the fixed RECALL_WAIT_CYC
                    if (st_q.op == OP_STORE) begin
                        st_d.tmr_count = STORE_WAIT;
                    end else begin
                        st_d.tmr_count = TMR_W'(RECALL_WAIT_CYC);
                    end
                    st_d.st = ST_NVWAIT;
                end
            end
            ST_NVWAIT: begin
                // no access until the transfer time is over
                // pins stay idle, the memory ignores them anyway
                if (wait_over(st_q.tmr_load, tif.expired)) begin
                    // memory is back in sram mode
                    st_d.rsp = 1'b1;
                    st_d.st = ST_IDLE;
                end
            end
            default: begin
                // unused codes fall back to the reset state
                st_d = CTL_RST;
            end
        endcase
    end

    // state register
    // async reset puts every pin at its idle level
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= CTL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // =====================================================
    // outputs
    // =====================================================
    // user side handshake, decoded from the state register
    assign req_ready = (st_q.st == ST_IDLE);
    assign busy = (st_q.st != ST_IDLE);

    // answer strobe and read data held in flops
    assign rsp_valid = st_q.rsp;
    assign rsp_rdata = st_q.rdata;

    // memory controls, registered so no glitch reaches the pins
    assign cs_n = st_q.cs_n;
    assign oe_n = st_q.oe_n;
    assign strobe_n = st_q.strobe_n;

    // address and write data; data only reaches the pins with its enable
    assign addr_pins = st_q.addr;
    assign data_pins_out = st_q.wdata;
    assign data_pins_oe = st_q.dq_oe;
endmodule
`default_nettype wire

// ==== nvsram_host_pkg.sv ====
package nvsram_host_pkg;

    // =====================================================
    // clock and timing
    // =====================================================
    localparam int CLK_PERIOD_NS = 100;
    localparam int ACC_LOW_NS = 500;       // cs_n low time per access
    localparam int STORE_MAX_MS = 10;      // software store duration
    localparam int RECALL_MAX_US = 20;     // software recall duration
    localparam int BOOT_RECALL_US = 650;   // power up recall duration
    localparam int TMR_W = 17;
    localparam int CNT_W = 4;

    // least time in ns rounded up to whole cycles, at least one
    function automatic int cyc_of_ns(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int ACC_LOW_CYC = cyc_of_ns(ACC_LOW_NS);
    localparam int STORE_WAIT_CYC = cyc_of_ns(STORE_MAX_MS * 1000000);
    localparam int RECALL_WAIT_CYC = cyc_of_ns(RECALL_MAX_US * 1000);
    localparam int BOOT_WAIT_CYC = cyc_of_ns(BOOT_RECALL_US * 1000);

    // =====================================================
    // pin widths and sequence addresses
    // =====================================================
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int SEQ_LAST = 5;
    localparam logic [ADDR_W-1:0] SEQ_A0 = 13'h0000;
    localparam logic [ADDR_W-1:0] SEQ_A1 = 13'h1555;
    localparam logic [ADDR_W-1:0] SEQ_A2 = 13'h0AAA;
    localparam logic [ADDR_W-1:0] SEQ_A3 = 13'h1FFF;
    localparam logic [ADDR_W-1:0] SEQ_A4 = 13'h10F0;
    localparam logic [ADDR_W-1:0] SEQ_STORE = 13'h0F0F;
    localparam logic [ADDR_W-1:0] SEQ_RECALL = 13'h0F0E;

    // =====================================================
    // types
    // =====================================================
    typedef enum logic [1:0] {
        OP_READ = 2'b00,
        OP_WRITE = 2'b01,
        OP_STORE = 2'b10,
        OP_RECALL = 2'b11
    } op_t;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b000,
        ST_IDLE = 3'b001,
        ST_SETUP = 3'b010,
        ST_ACT = 3'b011,
        ST_GAP = 3'b100,
        ST_NVWAIT = 3'b101
    } state_t;

    typedef struct packed {
        state_t st;
        op_t op;
        logic [2:0] seq;
        logic [CNT_W-1:0] cnt;
        logic boot_go;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic rsp;
        logic cs_n;
        logic oe_n;
        logic strobe_n;
        logic dq_oe;
        logic [DATA_W-1:0] s1;
        logic [DATA_W-1:0] s2;
        logic [DATA_W-1:0] s3;
        logic tmr_load;
        logic [TMR_W-1:0] tmr_count;
    } ctl_t;

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
    } tmr_t;

    // reset values
    localparam ctl_t CTL_RST = '{
        st: ST_BOOT, op: OP_READ, seq: 3'h0, cnt: 4'h0, boot_go: 1'b0,
        addr: 13'h0000, wdata: 8'h00, rdata: 8'h00, rsp: 1'b0,
        cs_n: 1'b1, oe_n: 1'b1, strobe_n: 1'b1, dq_oe: 1'b0,
        s1: 8'h00, s2: 8'h00, s3: 8'h00, tmr_load: 1'b0, tmr_count: 17'h00000
    };
    localparam tmr_t TMR_RST = '{cnt: 17'h00000};

endpackage

// ==== nv_timer_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// long wait timer link between controller and counter
// =====================================================
interface nv_timer_if;
    import nvsram_host_pkg::*;
    logic load;               // one cycle load strobe
    logic [TMR_W-1:0] count;  // cycles to wait
    logic expired;            // count has run out
    modport ctrl (output load, output count, input expired);
    modport tmr (input load, input count, output expired);
endinterface
`default_nettype wire

// ==== nv_wait_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// down counter for boot and nonvolatile busy waits
// =====================================================
module nv_wait_timer (
    input wire logic sys_clk,
    input wire logic sys_rst,
    nv_timer_if.tmr t
);
    import nvsram_host_pkg::*;

    tmr_t st_q; // counter state
    tmr_t st_d; // next counter state

    // load on strobe, else count toward zero
    always_comb begin
        st_d = st_q;
        if (t.load) begin
            st_d.cnt = t.count;
        end else if (st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - 17'h00001;
        end
    end

    // expired whenever the count sits at zero (also straight after reset) and no load is strobed
    assign t.expired = (st_q.cnt == '0) && !t.load;

    // state register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= TMR_RST;
        end else begin
            st_q <= st_d;
        end
    end
endmodule
`default_nettype wire

// ==== nvsram_host_ctrl_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// pin protocol checks on the host controller
// =====================================================
module nvsram_host_ctrl_props #(
    parameter logic [nvsram_host_pkg::TMR_W-1:0] STORE_WAIT = 17'h00014,
    parameter logic [nvsram_host_pkg::TMR_W-1:0] BOOT_WAIT = 17'h0000A
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic busy,
    input wire logic cs_n,
    input wire logic oe_n,
    input wire logic strobe_n,
    input wire logic [nvsram_host_pkg::ADDR_W-1:0] addr_pins,
    input wire logic data_pins_oe
);
    import nvsram_host_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // cycles since reset release, stops at the boot wait
    logic [TMR_W-1:0] boot_q;
    logic [TMR_W-1:0] boot_d;
    always_comb boot_d = (boot_q < BOOT_WAIT) ? boot_q + 1'b1 : boot_q;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) boot_q <= '0;
        else boot_q <= boot_d;
    end
    rst_idle_a: assert property (disable iff (1'b0) sys_rst |->
        cs_n && oe_n && strobe_n && !data_pins_oe && !rsp_valid) else $error("pins not idle");
    boot_quiet_a: assert property (boot_q < BOOT_WAIT |-> cs_n && !req_ready)
        else $error("access during boot recall");
    cs_width_a: assert property ($fell(cs_n) |-> (!cs_n) [*5] ##1 cs_n)
        else $error("select pulse width");
    addr_hold_a: assert property (!cs_n |-> $stable(addr_pins))
        else $error("address moved while selected");
    write_ctl_a: assert property (!strobe_n |-> !cs_n && oe_n && data_pins_oe)
        else $error("write controls");
    write_end_a: assert property ($rose(strobe_n) |-> $rose(cs_n) && data_pins_oe
        ##1 rsp_valid && !data_pins_oe) else $error("write end");
    read_rsp_a: assert property ($rose(cs_n) && !$past(oe_n) |-> ##[1:2] rsp_valid)
        else $error("read answer late");
    read_float_a: assert property (!cs_n && strobe_n |-> !data_pins_oe)
        else $error("host drives during read");
    take_busy_a: assert property (req_valid && req_ready |=> busy && !req_ready)
        else $error("request not taken");
    rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer longer than one cycle");
endmodule
`default_nettype wire

// ==== nvsram_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// behavioural nonvolatile sram on the far side
// =====================================================
module nvsram_dev_model (
    input wire logic cs_n,
    input wire logic oe_n,
    input wire logic strobe_n,
    input wire logic [12:0] addr_pins,
    input wire logic [7:0] data_pins_out,
    input wire logic data_pins_oe,
    output logic [7:0] data_pins_in
);
    localparam logic [12:0] SA [5] = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
    logic [7:0] mem [8192];
    logic [7:0] nv [8192];
    logic [12:0] last_a = 13'h1ABC; // previous sequence read
    logic [7:0] last_q = 8'h00; // last byte driven
    logic nv_busy = 1'h0;
    logic wr = 1'h0;
    logic supply_ok = 1'h1; // supply above trip level
    logic dirty = 1'h0; // a write landed since the last transfer
    int seq = 0;
    int n_store = 0;
    int n_recall = 0;
    wire drv = !cs_n && !oe_n && strobe_n && !nv_busy;
    // released lines show the inverse of the last byte
    assign data_pins_in = drv ? mem[addr_pins] : data_pins_oe ? data_pins_out : ~last_q;
    always @* if (drv) last_q = mem[addr_pins];
    // nonvolatile copy runs alone, pins ignored
    task automatic nv_go(input logic rec);
        nv_busy = 1'h1;
        seq = 0;
        dirty = 1'h0;
        if (rec) begin
            mem = '{default: 8'h00};
            #5000 mem = nv;
            n_recall++;
        end else begin
            if (supply_ok) nv = mem;
            #1000 n_store++;
        end
        nv_busy = 1'h0;
    endtask
    // sequence reads are clocked by the select fall
    always @(negedge cs_n) begin
        #1;
        if (!nv_busy && strobe_n) begin
            last_a <= addr_pins;
            if (seq == 5 && (addr_pins == 13'h0F0F || addr_pins == 13'h0F0E))
                nv_go(!addr_pins[0]);
            else if (addr_pins == SA[seq] && addr_pins != last_a) seq++;
            else seq = int'(addr_pins == 13'h0000);
        end
        if (!nv_busy && !strobe_n) wr = 1'h1;
    end
    always @(negedge strobe_n) #1 if (!nv_busy && !cs_n) wr = 1'h1;
    // write lands at whichever control rises first
    always @(posedge cs_n or posedge strobe_n) begin
        if (wr) begin
            mem[addr_pins] = data_pins_out;
            wr = 1'h0;
            dirty = 1'h1;
            seq = 0;
        end
    end
    // automatic store on supply fall, skipped when nothing was written
    always @(negedge supply_ok) if (dirty && !nv_busy) begin
        nv = mem;
        dirty = 1'h0;
    end
endmodule
`default_nettype wire

// ==== nvsram_host_ctrl_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module nvsram_host_ctrl_test;
    import nvsram_host_pkg::*;
    // =====================================================
    // clock, reset and pins
    // =====================================================
    logic sys_clk = 1'h0;
    logic sys_rst = 1'h0; // raised just after time zero so the async reset sees an edge
    logic req_valid = 1'h0;
    op_t req_op = OP_READ;
    logic [ADDR_W-1:0] req_addr = 13'h0000;
    logic [DATA_W-1:0] req_wdata = 8'h00;
    logic req_ready, rsp_valid, busy, cs_n, oe_n, strobe_n, data_pins_oe;
    logic [ADDR_W-1:0] addr_pins;
    logic [DATA_W-1:0] data_pins_in, data_pins_out, rsp_rdata;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    initial forever #50 sys_clk = ~sys_clk;
    nvsram_host_ctrl #(.STORE_WAIT(17'h00014), .BOOT_WAIT(17'h0000A)) i_nvsram_host_ctrl (
        .sys_clk, .sys_rst, .req_valid, .req_ready, .req_op, .req_addr, .req_wdata,
        .rsp_valid, .rsp_rdata, .busy, .cs_n, .oe_n, .strobe_n, .addr_pins,
        .data_pins_in, .data_pins_out, .data_pins_oe);
    nvsram_dev_model i_nvsram_dev_model (.cs_n, .oe_n, .strobe_n, .addr_pins,
        .data_pins_out, .data_pins_oe, .data_pins_in);
    // =====================================================
    // report helpers
    // =====================================================
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            results();
        end
    end
    // one request, n counts cycles from take to answer
    task automatic run(input op_t op, input logic [12:0] a, input logic [7:0] d, output int n);
        @(posedge sys_clk) #10;
        n = 0;
        req_op = op;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'h1;
        while (req_ready !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk) #10 req_valid = 1'h0;
        while (rsp_valid !== 1'b1) begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    // =====================================================
    // scenarios
    // =====================================================
    task automatic t_boot();
        int n;
        n = 0;
        #1 sys_rst = 1'h1;
        repeat (4) @(posedge sys_clk);
        check("reset pins", {req_ready, busy, cs_n, data_pins_oe}, 4'h6);
        #10 sys_rst = 1'h0;
        while (req_ready !== 1'b1) begin
            @(negedge sys_clk);
            n++;
        end
        check("boot wait", n >= 10, 1'h1);
    endtask
    task automatic t_rw();
        logic [12:0] a [4] = '{13'h0000, 13'h1FFF, 13'h1555, 13'h0AAA};
        int n;
        foreach (a[i]) run(OP_WRITE, a[i], a[i][7:0] ^ 8'h5A, n);
        foreach (a[i]) begin
            run(OP_READ, a[i], 8'h00, n);
            check("read data", rsp_rdata, a[i][7:0] ^ 8'h5A);
            check("stored byte", i_nvsram_dev_model.mem[a[i]], a[i][7:0] ^ 8'h5A);
        end
    endtask
    task automatic t_nv();
        int n;
        run(OP_WRITE, 13'h0123, 8'hC3, n);
        run(OP_STORE, 13'h0000, 8'h00, n);
        check("store time", n >= 60 && n <= 72, 1'h1);
        check("stores", i_nvsram_dev_model.n_store, 16'h0001);
        run(OP_WRITE, 13'h0123, 8'h3C, n);
        run(OP_RECALL, 13'h0000, 8'h00, n);
        check("recall time", n >= 240 && n <= 252, 1'h1);
        check("recalls", i_nvsram_dev_model.n_recall, 16'h0001);
        run(OP_READ, 13'h0123, 8'h00, n);
        check("recalled byte", rsp_rdata, 8'hC3);
    endtask
    initial begin
        t_boot();
        t_rw();
        t_nv();
        results();
    end
endmodule
bind nvsram_host_ctrl nvsram_host_ctrl_props #(.STORE_WAIT(STORE_WAIT), .BOOT_WAIT(BOOT_WAIT))
    i_nvsram_host_ctrl_props (.sys_clk, .sys_rst, .req_valid, .req_ready, .rsp_valid, .busy,
    .cs_n, .oe_n, .strobe_n, .addr_pins, .data_pins_oe);
`default_nettype wire
